// ==== core/umsm_bank.sv ====
// Status and mask register bank of the upset monitor, AXI4-Lite slave.
// Assumes monitor events are synchronous to aclk and one master.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module umsm_bank
	import umsm_pkg::*;
#(
	parameter int MON_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [MON_W-1:0] monitor_event,
	output logic soft_recovery_req,
	output logic recovery_interrupt_n,
	output logic irq
);
	umsm_state_t state_reg;
	umsm_state_t state_next;
	logic [STAT_W-1:0] status_view;
	logic [FLAG_N-1:0] flag_set;
	logic [FLAG_N-1:0] flag_clr;
	logic [15:0] wmask;
	logic [9:0] ar_idx;
	logic wr_fire;

	// Events that latch the sticky flags, bits 8 to 11 of the status.
	assign flag_set = monitor_event[FLAG_LO +: FLAG_N];

	// Reserved upper bits are tied low; lower bits show live inputs.
	always_comb begin
		status_view = STATUS_RESET;
		status_view[FLAG_LO-1:0] = monitor_event[FLAG_LO-1:0];
		status_view[BIT_INACTIVE] = state_reg.flags[0]; // RQ5
		status_view[BIT_PPM_UNLOCK] = state_reg.flags[1]; // RQ4
		status_view[BIT_FREQ_UNLOCK] = state_reg.flags[2]; // RQ3
		status_view[BIT_PLL_FAIL] = state_reg.flags[3]; // RQ8
	end

	// Byte enables expand to a bit mask over the 16-bit registers.
	assign wmask = {{8{state_reg.wstrb[1]}}, {8{state_reg.wstrb[0]}}};
	assign ar_idx = s_axi_araddr[ADDR_LSB +: 10];
	// A write completes once address and data are both held.
	assign wr_fire = state_reg.aw_have && state_reg.w_have
		&& !state_reg.bvalid;

	// Handshake outputs follow the held state directly.
	assign s_axi_awready = !state_reg.aw_have && !state_reg.bvalid;
	assign s_axi_wready = !state_reg.w_have && !state_reg.bvalid;
	assign s_axi_arready = !state_reg.rvalid;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;
	assign soft_recovery_req = state_reg.soft_req;
	assign recovery_interrupt_n = state_reg.rec_n;
	assign irq = state_reg.irq;

	// Whole next-state computation; bus, flags and recovery outputs.
	always_comb begin
		state_next = state_reg;
		flag_clr = '0;
		// Address and data are taken independently, in either order.
		if (s_axi_awvalid && s_axi_awready) begin
			state_next.aw_have = 1'b1;
			state_next.aw_idx = s_axi_awaddr[ADDR_LSB +: 10];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			state_next.w_have = 1'b1;
			state_next.wdata = s_axi_wdata;
			state_next.wstrb = s_axi_wstrb;
		end
		if (wr_fire) begin
			state_next.aw_have = 1'b0;
			state_next.w_have = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = RESP_OKAY;
			case (state_reg.aw_idx)
				IDX_SOFT_MASK: begin
					state_next.soft_mask = (state_reg.soft_mask & ~wmask)
						| (state_reg.wdata[15:0] & wmask); // RQ1
				end
				IDX_EXT_MASK: begin
					state_next.ext_mask = (state_reg.ext_mask & ~wmask)
						| (state_reg.wdata[15:0] & wmask); // RQ2
				end
				IDX_STATUS, IDX_IRQ_CLEAR: begin
					// Writing one clears; the status is also the clear port.
					flag_clr = state_reg.wdata[FLAG_LO +: FLAG_N]
						& wmask[FLAG_LO +: FLAG_N]; // RQ6
				end
				IDX_IRQ_ENABLE: begin
					state_next.irq_en = (state_reg.irq_en & ~wmask)
						| (state_reg.wdata[15:0] & wmask);
				end
				default: begin
					state_next.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end
		// Reads answer one cycle after the address is taken.
		if (s_axi_arvalid && s_axi_arready) begin
			state_next.rvalid = 1'b1;
			state_next.rresp = RESP_OKAY;
			state_next.rdata = 32'h0000_0000;
			case (ar_idx)
				IDX_SOFT_MASK: state_next.rdata[15:0] = state_reg.soft_mask;
				IDX_EXT_MASK: state_next.rdata[15:0] = state_reg.ext_mask;
				IDX_STATUS: state_next.rdata[15:0] = status_view; // RQ7
				IDX_IRQ_CLEAR: state_next.rdata = 32'h0000_0000;
				IDX_IRQ_ENABLE: state_next.rdata[15:0] = state_reg.irq_en;
				default: state_next.rresp = RESP_SLVERR;
			endcase
		end else if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid = 1'b0;
		end
		// A new event beats a clear in the same cycle so none is lost.
		state_next.flags = (state_reg.flags & ~flag_clr)
			| flag_set; // RQ3 RQ4 RQ5 RQ8
		// Soft recovery is a single pulse on a newly permitted input.
		state_next.soft_hit = |(monitor_event & state_reg.soft_mask); // RQ1
		state_next.soft_req = state_next.soft_hit && !state_reg.soft_hit;
		// External recovery stays low while any permitted status bit, 11 to 0, is set; bits 15..12 never count.
		state_next.rec_n = ~|(status_view & state_reg.ext_mask); // RQ2
		state_next.irq = |(status_view & state_reg.irq_en);
	end

	// Synchronous reset; every field takes a constant.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
			state_reg.soft_mask <= MASK_RESET; // RQ1
			state_reg.ext_mask <= MASK_RESET; // RQ2
			state_reg.irq_en <= IRQ_EN_RESET;
			state_reg.flags <= '0; // RQ6
			state_reg.rec_n <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end
endmodule
`default_nettype wire

// ==== core/umsm_pkg.sv ====
// Constants for the upset monitor status and mask register bank.
// Assumes an AXI4-Lite master with 32-bit data on a single clock.
// Behaviour
// (RQ1) Soft recovery mask, 16 bits, resets all ones.
// (RQ2) External recovery mask, 16 bits, resets all ones.
// (RQ3) Bit 10 latches system clock frequency unlock.
// (RQ4) Bit 9 latches system clock tolerance unlock.
// (RQ5) Bit 8 latches system clock inactive.
// (RQ6) Flags clear by write one or reset.
// (RQ7) Status bits 15 to 12 read zero.
// (RQ8) Bit 11 latches PLL lock detect failure.
package umsm_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [9:0] IDX_SOFT_MASK = 10'h1D6;
	localparam logic [9:0] IDX_EXT_MASK = 10'h1D7;
	localparam logic [9:0] IDX_STATUS = 10'h1D8;
	localparam logic [9:0] IDX_IRQ_CLEAR = 10'h1E0;
	localparam logic [9:0] IDX_IRQ_ENABLE = 10'h1E1;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_W = 12;
	// Field layout of the status word.
	localparam int STAT_W = 16;
	localparam int FLAG_LO = 8;
	localparam int FLAG_N = 4;
	localparam int BIT_INACTIVE = 8;
	localparam int BIT_PPM_UNLOCK = 9;
	localparam int BIT_FREQ_UNLOCK = 10;
	localparam int BIT_PLL_FAIL = 11;
	// Reset values.
	localparam logic [15:0] MASK_RESET = 16'hFFFF;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] IRQ_EN_RESET = 16'h0000;
	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// All state of the bank.
	typedef struct packed {
		logic [15:0] soft_mask;
		logic [15:0] ext_mask;
		logic [3:0] flags;
		logic [15:0] irq_en;
		logic aw_have;
		logic [9:0] aw_idx;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic soft_hit;
		logic soft_req;
		logic rec_n;
		logic irq;
	} umsm_state_t;
endpackage

// ==== sim/umsm_bank_properties.sv ====
// Concurrent checks on the ports of the upset monitor register bank.
// Assumes a single aclk domain with synchronous active-low aresetn.
`timescale 1ns/1ns
`default_nettype none
module umsm_bank_props #(
	parameter int MON_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [MON_W-1:0] monitor_event,
	input wire logic soft_recovery_req,
	input wire logic recovery_interrupt_n,
	input wire logic irq
);
	// Reset checks override the default disable, since they watch reset.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_soft_cause: assert property (soft_recovery_req |-> $past(|monitor_event))
		else $error("soft recovery request without a monitor event");
	a_soft_pulse: assert property (soft_recovery_req |=> !soft_recovery_req)
		else $error("soft recovery request longer than one cycle");
	a_ext_reset: assert property (disable iff (1'h0)
		!aresetn |=> recovery_interrupt_n)
		else $error("recovery interrupt active after reset");
	a_irq_reset: assert property (disable iff (1'h0)
		!aresetn |=> !irq && !soft_recovery_req)
		else $error("interrupt or request active after reset");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not one cycle after address");
	a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data held after handshake");
	a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response held after handshake");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
		else $error("upper read data not zero");
endmodule
bind umsm_bank umsm_bank_props #(.MON_W(MON_W)) umsm_bank_props_inst (.*);
`default_nettype wire

// ==== sim/umsm_bank_tb_top.sv ====
// Self-checking bench for the upset monitor register bank.
// Assumes the checker is bound and one 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module umsm_bank_tb_top
	import umsm_pkg::*;
;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, soft_recovery_req, recovery_interrupt_n, irq;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] monitor_event = 16'h0;
	int miscompares = 0, n_compared = 0;
	umsm_bank umsm_bank_inst (.*);
	initial forever #20 aclk = ~aclk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Handshakes are judged at the falling edge, acted on at the next rise.
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic ha, hw, hb;
		logic [1:0] g;
		hb = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (int n = 0; n < 50 && !hb; n++) begin
			@(negedge aclk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid && s_axi_bready;
			g = s_axi_bresp;
			@(posedge aclk);
			if (ha) s_axi_awvalid <= 1'h0;
			if (hw) s_axi_wvalid <= 1'h0;
			if (hb) s_axi_bready <= 1'h0;
		end
		if (!hb) miscompares++;
		if (!hb) conclude();
		chk(g, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] r);
		logic ha, hr;
		logic [31:0] g;
		logic [1:0] gr;
		hr = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (int n = 0; n < 50 && !hr; n++) begin
			@(negedge aclk);
			ha = s_axi_arvalid && s_axi_arready;
			hr = s_axi_rvalid && s_axi_rready;
			g = s_axi_rdata;
			gr = s_axi_rresp;
			@(posedge aclk);
			if (ha) s_axi_arvalid <= 1'h0;
			if (hr) s_axi_rready <= 1'h0;
		end
		if (!hr) miscompares++;
		if (!hr) conclude();
		chk(g, e);
		chk(gr, r);
	endtask
	// Counts request pulses over four cycles after the inputs change.
	task automatic pulses(input logic [15:0] v, input int e);
		int c;
		c = 0;
		@(posedge aclk);
		monitor_event <= v;
		repeat (4) @(negedge aclk) c += soft_recovery_req;
		chk(c, e);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		rd(12'h758, 32'hFFFF, RESP_OKAY);
		rd(12'h75C, 32'hFFFF, RESP_OKAY);
		rd(12'h760, 32'h0, RESP_OKAY);
		rd(12'h7FC, 32'h0, RESP_SLVERR);
		wr(12'h758, 32'hA5C3, RESP_OKAY);
		rd(12'h758, 32'hA5C3, RESP_OKAY);
		wr(12'h784, 32'h0F00, RESP_OKAY);
		$display("test reset and masks done");
		// High bits 15..12 stay driven; they must never reach the status.
		for (int b = 8; b < 12; b++) begin
			@(posedge aclk);
			monitor_event <= 16'hF000 | (16'h1 << b);
			@(posedge aclk);
			monitor_event <= 16'hF000;
			rd(12'h760, 32'h1 << b, RESP_OKAY);
			chk(irq, 1'h1);
			wr(b[0] ? 12'h780 : 12'h760, 32'h1 << b, RESP_OKAY);
			rd(12'h760, 32'h0, RESP_OKAY);
			chk(irq, 1'h0);
		end
		$display("test flags done");
		wr(12'h758, 32'h0002, RESP_OKAY);
		wr(12'h75C, 32'h0001, RESP_OKAY);
		rd(12'h75C, 32'h0001, RESP_OKAY);
		pulses(16'h0001, 0);
		chk(recovery_interrupt_n, 1'h0);
		pulses(16'h0002, 1);
		chk(recovery_interrupt_n, 1'h1);
		$display("test recovery done");
		conclude();
	end
endmodule
`default_nettype wire
